// ### sbc_pkg.sv
package sbc_pkg;
  localparam int          SBC_W          = 4;
  localparam logic [3:0]  SBC_CNT_RST    = 4'h0;
  localparam logic [3:0]  SBC_CNT_ONE    = 4'h1;
  localparam logic [3:0]  SBC_CNT_MAX    = 4'hF;
  localparam logic [11:0] SBC_OFF_CTRL   = 12'h000;
  localparam logic [11:0] SBC_OFF_STATUS = 12'h004;
  localparam int          SBC_CTRL_GATE  = 0;
  localparam int          SBC_ST_CNT_LO  = 0;
  localparam int          SBC_ST_TERM    = 4;
  localparam int          SBC_ST_LOAD_N  = 5;
  localparam logic        SBC_GATE_RST   = 1'b1;
  localparam logic [31:0] SBC_ZERO32     = 32'h0000_0000;

  typedef enum logic [1:0] {
    SBC_APB_IDLE = 2'b01,
    SBC_APB_ACK  = 2'b10
  } sbc_apb_st_t;

  typedef struct packed {
    logic             count_clock;
    logic             load_n;
    logic             count_enable_parallel;
    logic             count_enable_carry;
    logic [SBC_W-1:0] preset_data;
  } sbc_pins_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } sbc_apb_req_t;
endpackage

// ### sbc_counter.sv
// Functional notes
// - four-bit binary count held in four flip-flops, shown on four outputs
// - count changes only at rising count_clock edges, except the clear
// - load_n low at a count_clock edge copies preset_data into the count
// - load wins over counting; both enables ignored while load_n low
// - load_n high, both enables high and the ctrl gate bit set: count advances by one
// - load_n high and either enable low: count holds
// - terminal_flag high only for count fifteen with carry enable high
// - clear low forces count outputs and terminal_flag low
// - clear acts asynchronously, overriding load and counting
`timescale 1ns/1ps
`default_nettype none
module sbc_counter (
  // clock and reset
  input  wire logic                 CLK,
  input  wire logic                 RST_N,
  // counter pins
  input  wire logic                 ASYNC_CLEAR_N,
  input  wire sbc_pkg::sbc_pins_t   PINS_IN,
  output logic [sbc_pkg::SBC_W-1:0] COUNT_OUT,
  output logic                      TERMINAL_FLAG,
  // apb slave
  input  wire sbc_pkg::sbc_apb_req_t APB_REQ,
  output logic [31:0]               PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR
);
  import sbc_pkg::*;

  function automatic logic all_ones(input logic [SBC_W-1:0] v);
    return v == SBC_CNT_MAX;
  endfunction

  // clear drops the count at once; its release passes two flops so that
  // count_r never leaves reset close to an edge. pin glitches still clear it
  logic       clr_raw_n;
  logic [1:0] clr_sync_r, clr_sync_nxt;
  logic       clr_n;

  assign clr_raw_n = RST_N & ASYNC_CLEAR_N;

  always_comb begin
    clr_sync_nxt = {clr_sync_r[0], 1'b1};
  end

  always_ff @(posedge CLK or negedge clr_raw_n) begin
    if (!clr_raw_n) begin
      clr_sync_r <= '0;
    end else begin
      clr_sync_r <= clr_sync_nxt;
    end
  end

  assign clr_n = clr_sync_r[1];

  // two-flop synchronisers for all pin inputs except ASYNC_CLEAR_N
  sbc_pins_t s1_r, s2_r, s1_nxt, s2_nxt;
  logic      clk_prev_r, clk_prev_nxt;
  logic      edge_hit;

  always_comb begin
    s1_nxt       = PINS_IN;
    s2_nxt       = s1_r;
    clk_prev_nxt = s2_r.count_clock;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s1_r       <= '0;
      s2_r       <= '0;
      clk_prev_r <= 1'b0;
    end else begin
      s1_r       <= s1_nxt;
      s2_r       <= s2_nxt;
      clk_prev_r <= clk_prev_nxt;
    end
  end

  assign edge_hit = s2_r.count_clock & ~clk_prev_r;

  // count state
  logic [SBC_W-1:0] count_r, count_nxt;
  logic             term_r, term_nxt;
  logic             gate_r;
  logic             do_count;

  assign do_count = s2_r.load_n & s2_r.count_enable_parallel & s2_r.count_enable_carry & gate_r;

  always_comb begin
    count_nxt = count_r;
    if (edge_hit) begin
      if (!s2_r.load_n) begin
        count_nxt = s2_r.preset_data;
      end else if (do_count) begin
        count_nxt = all_ones(count_r) ? SBC_CNT_RST : count_r + SBC_CNT_ONE;
      end
    end
    term_nxt = all_ones(count_nxt) & s2_r.count_enable_carry;
  end

  // flag registered one cycle after the synchronised carry enable
  always_ff @(posedge CLK or negedge clr_n) begin
    if (!clr_n) begin
      count_r <= SBC_CNT_RST;
      term_r  <= 1'b0;
    end else begin
      count_r <= count_nxt;
      term_r  <= term_nxt;
    end
  end

  assign COUNT_OUT     = count_r;
  assign TERMINAL_FLAG = term_r;

  // apb slave, zero wait: pready rises in the access cycle
  sbc_apb_st_t st_r, st_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        err_r, err_nxt;
  logic        ready_r, ready_nxt;
  logic        gate_nxt;
  logic        hit_ctrl, hit_stat;

  assign hit_ctrl = APB_REQ.paddr == SBC_OFF_CTRL;
  assign hit_stat = APB_REQ.paddr == SBC_OFF_STATUS;

  always_comb begin
    st_nxt    = SBC_APB_IDLE;
    rdata_nxt = rdata_r;
    err_nxt   = 1'b0;
    ready_nxt = 1'b0;
    gate_nxt  = gate_r;
    unique case (st_r)
      SBC_APB_IDLE: begin
        if (APB_REQ.psel && !APB_REQ.penable) begin
          st_nxt    = SBC_APB_ACK;
          ready_nxt = 1'b1;
          err_nxt   = !(hit_ctrl || hit_stat);
          rdata_nxt = SBC_ZERO32;
          if (!APB_REQ.pwrite && hit_ctrl) begin
            rdata_nxt[SBC_CTRL_GATE] = gate_r;
          end
          if (!APB_REQ.pwrite && hit_stat) begin
            rdata_nxt[SBC_ST_CNT_LO +: SBC_W] = count_r;
            rdata_nxt[SBC_ST_TERM]            = term_r;
            rdata_nxt[SBC_ST_LOAD_N]          = s2_r.load_n;
          end
        end
      end
      SBC_APB_ACK: begin
        // write lands at the edge where pready is sampled high
        if (APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite && hit_ctrl) begin
          gate_nxt = APB_REQ.pwdata[SBC_CTRL_GATE];
        end
      end
      default: st_nxt = SBC_APB_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r    <= SBC_APB_IDLE;
      rdata_r <= SBC_ZERO32;
      err_r   <= 1'b0;
      ready_r <= 1'b0;
      gate_r  <= SBC_GATE_RST;
    end else begin
      st_r    <= st_nxt;
      rdata_r <= rdata_nxt;
      err_r   <= err_nxt;
      ready_r <= ready_nxt;
      gate_r  <= gate_nxt;
    end
  end

  assign PREADY  = ready_r;
  // err_nxt is only set on the way into the ack state
  assign PSLVERR = err_r;
  assign PRDATA  = rdata_r;

  // checks
  a_load_copies: assert property (@(posedge CLK) disable iff (!clr_n)
    edge_hit && !s2_r.load_n |=> count_r == $past(s2_r.preset_data))
    else $error("load did not copy preset");
  a_load_priority: assert property (@(posedge CLK) disable iff (!clr_n)
    edge_hit && !s2_r.load_n && s2_r.count_enable_parallel |=> count_r == $past(s2_r.preset_data, 1))
    else $error("count took priority over load");
  a_count_step: assert property (@(posedge CLK) disable iff (!clr_n)
    edge_hit && do_count && !all_ones(count_r) |=> count_r == $past(count_r) + SBC_CNT_ONE)
    else $error("count did not advance");
  a_count_hold: assert property (@(posedge CLK) disable iff (!clr_n)
    edge_hit && s2_r.load_n && !s2_r.count_enable_carry |=> $stable(count_r))
    else $error("count changed with enable low");
  a_no_edge_hold: assert property (@(posedge CLK) disable iff (!clr_n)
    !edge_hit |=> $stable(count_r))
    else $error("count changed without clock edge");
  a_term_flag: assert property (@(posedge CLK) disable iff (!clr_n)
    ##1 TERMINAL_FLAG == (all_ones(COUNT_OUT) && $past(s2_r.count_enable_carry)))
    else $error("terminal flag wrong");
  a_wrap_zero: assert property (@(posedge CLK) disable iff (!clr_n)
    edge_hit && do_count && all_ones(count_r) |=> count_r == SBC_CNT_RST)
    else $error("no wrap to zero");
  a_clear_low: assert property (@(posedge CLK)
    !ASYNC_CLEAR_N |-> COUNT_OUT == SBC_CNT_RST && !TERMINAL_FLAG)
    else $error("clear did not force outputs low");
  a_apb_ack: assert property (@(posedge CLK) disable iff (!RST_N)
    APB_REQ.psel && !APB_REQ.penable && !PREADY |=> PREADY ##1 !PREADY)
    else $error("apb answer not one cycle");
  a_cep_hold: assert property (@(posedge CLK) disable iff (!clr_n)
    edge_hit && s2_r.load_n && !s2_r.count_enable_parallel |=> $stable(count_r))
    else $error("count changed with parallel enable low");
  a_term_needs_max: assert property (@(posedge CLK) disable iff (!clr_n)
    TERMINAL_FLAG |-> all_ones(COUNT_OUT))
    else $error("terminal flag high below fifteen");
  a_err_with_ready: assert property (@(posedge CLK) disable iff (!RST_N)
    PSLVERR |-> PREADY)
    else $error("error reported outside access cycle");

  c_load: cover property (@(posedge CLK) disable iff (!clr_n) edge_hit && !s2_r.load_n);
  c_wrap: cover property (@(posedge CLK) disable iff (!clr_n) edge_hit && do_count && all_ones(count_r));
  c_term: cover property (@(posedge CLK) disable iff (!clr_n) TERMINAL_FLAG);
  c_clear: cover property (@(posedge CLK) $fell(ASYNC_CLEAR_N));
  c_carry_out: cover property (@(posedge CLK) disable iff (!clr_n) TERMINAL_FLAG && edge_hit && do_count);
endmodule
`default_nettype wire

// ### sbc_pin_drv.sv
`timescale 1ns/1ps
`default_nettype none
module sbc_pin_drv (
  // clock
  input  wire logic            CLK,
  // pins toward the counter
  output var sbc_pkg::sbc_pins_t PINS
);
  import sbc_pkg::*;
  initial PINS = '0;
  // controls settle three cycles ahead, since the pins pass two sync flops
  task automatic step(input logic ld, input logic ep, input logic ec, input logic [3:0] pd);
    PINS <= '{1'b0, ld, ep, ec, pd};
    repeat (3) @(posedge CLK);
    PINS.count_clock <= 1'b1;
    repeat (3) @(posedge CLK);
    PINS.count_clock <= 1'b0;
    repeat (2) @(posedge CLK);
  endtask
endmodule
`default_nettype wire

// ### sync_binary_counter_4bit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sync_binary_counter_4bit_tb_top;
  import sbc_pkg::*;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         clr_n = 1'b1;
  sbc_pins_t    pins;
  sbc_apb_req_t req = '0;
  logic [3:0]   cnt;
  logic         tflag;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [3:0]   c = 4'h0;
  logic         g = 1'b1;
  logic [31:0]  rd;
  logic         er;
  logic         f;
  int           hi = 0;
  int           error_cnt = 0;
  int           samples_checked = 0;
  always #4 clk = ~clk;
  sbc_pin_drv drv_u (.CLK(clk), .PINS(pins));
  sbc_counter dut_u (.CLK(clk), .RST_N(rst_n), .ASYNC_CLEAR_N(clr_n), .PINS_IN(pins), .COUNT_OUT(cnt),
    .TERMINAL_FLAG(tflag), .APB_REQ(req), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      error_cnt++;
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // pready is read before the edge's own updates land, i.e. as sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    req <= '0;
    // one idle edge so a following call never re-drives req in this time step
    @(posedge clk);
  endtask
  task automatic run(input logic ld, input logic ep, input logic ec, input logic [3:0] pd);
    drv_u.step(ld, ep, ec, pd);
    c = ld ? ((ep && ec && g) ? c + 4'h1 : c) : pd;
    chk("count", {28'h0, cnt}, {28'h0, c});
    chk("flag", {31'h0, tflag}, {31'h0, c == SBC_CNT_MAX && ec});
    apb(1'b0, SBC_OFF_STATUS, SBC_ZERO32);
    chk("status", rd, {26'h0, ld, c == SBC_CNT_MAX && ec, c});
  endtask
  initial begin
    #400000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    void'($urandom(44030));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, SBC_OFF_CTRL, SBC_ZERO32);
    chk("ctrl_rst", rd, {31'h0, SBC_GATE_RST});
    apb(1'b0, 12'h008, SBC_ZERO32);
    chk("unmapped", {rd[30:0], er}, 32'h1);
    run(1'b0, 1'b0, 1'b0, SBC_CNT_MAX);
    run(1'b1, 1'b0, 1'b1, 4'h3);
    run(1'b1, 1'b1, 1'b1, 4'h3);
    for (int i = 0; i < 40; i++) begin
      g = $urandom % 4 != 0;
      apb(1'b1, SBC_OFF_CTRL, {31'h0, g});
      run($urandom % 4 != 0, $urandom % 2 != 0, $urandom % 3 != 0, 4'($urandom));
    end
    g = 1'b1;
    apb(1'b1, SBC_OFF_CTRL, {31'h0, g});
    // bench-side upper stage: its carry enable is our flag at each count edge
    run(1'b0, 1'b1, 1'b1, SBC_CNT_RST);
    for (int k = 0; k < 32; k++) begin
      f = tflag;
      run(1'b1, 1'b1, 1'b1, SBC_CNT_RST);
      if (f) hi++;
    end
    chk("cascade", hi, 32'h2);
    run(1'b0, 1'b0, 1'b1, SBC_CNT_MAX);
    // dropped where no count edge is due and checked before the next clock edge
    @(posedge clk);
    clr_n <= 1'b0;
    #1 chk("clear", {27'h0, tflag, cnt}, 32'h0);
    @(posedge clk);
    clr_n <= 1'b1;
    c = 4'h0;
    repeat (3) @(posedge clk);
    chk("clear_release", {28'h0, cnt}, {28'h0, c});
    end_of_test();
  end
endmodule
`default_nettype wire
